// *** include/drive_status_pkg.sv ***
// Constants, register map and carrier types for the drive status block.
// Assumes a 100 MHz core clock and an APB master with 32-bit data.
//
// What this block does
// - Overload warning asserts while motor current exceeds threshold, 0 to 200 percent.
// - Overload warning only drives a logic output; never trips or limits current.
// - Ramping up, output frequency compares to accel arrival threshold, 0-400 Hz.
// - Ramping down, output frequency compares to separate decel arrival threshold.
// - PID error is absolute difference of setpoint and process value.
// - With output option 04 selected, deviation flag asserts when error exceeds limit.
// - Deviation limit spans 0.0 to 100 percent in 0.1 steps, default 3.0.
// - Second stage output clears when process value rises above high limit.
// - Second stage output sets when process value falls below low limit.
// - Link rate code 04, 05, 06 selects 4800, 9600, 19200; default 04.
// - Node address programmable 1 to 32, default 1; master uses it.
// - Parity code 00 none, 01 even, 02 odd; both ends agree.
// - One or two stop bits, default one; both ends agree.
// - Link error reaction: trip, decel-trip, ignore, coast, decel stop.
// - Link watchdog period 0.00 to 99.99 s in 0.01 s steps.
// - Reply is held off 0 to 1000 ms after a message arrives.
// - Watchdog expiry asserts link loss flag; traffic releases it.
// - Second stage output clears whenever the drive leaves run mode.
package drive_status_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_OVL = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_DEC = 8'h08;
  localparam logic [7:0] OFF_DEV = 8'h0c;
  localparam logic [7:0] OFF_HIGH = 8'h10;
  localparam logic [7:0] OFF_LOW = 8'h14;
  localparam logic [7:0] OFF_LINK = 8'h18;
  localparam logic [7:0] OFF_NODE = 8'h1c;
  localparam logic [7:0] OFF_REACT = 8'h20;
  localparam logic [7:0] OFF_WDOG = 8'h24;
  localparam logic [7:0] OFF_WAIT = 8'h28;
  localparam logic [7:0] OFF_FUNC = 8'h2c;
  localparam logic [7:0] OFF_STAT = 8'h30;
  localparam logic [7:0] OFF_IRQ = 8'h34;
  localparam logic [7:0] OFF_MASK = 8'h38;
  localparam logic [7:0] OFF_PERR = 8'h3c;

  // ------------------------------------------------------------------
  // Field positions of the link setup register
  // ------------------------------------------------------------------
  localparam int LINK_RATE_LSB = 0;
  localparam int LINK_PAR_LSB = 8;
  localparam int LINK_STOP_LSB = 16;

  // ------------------------------------------------------------------
  // Limits and reset values (percent in 0.1 %, frequency in 0.1 Hz)
  // ------------------------------------------------------------------
  localparam logic [11:0] OVL_MAX = 12'h7d0;
  localparam logic [11:0] OVL_RST = 12'h3e8;
  localparam logic [11:0] FREQ_MAX = 12'hfa0;
  localparam logic [11:0] FREQ_RST = 12'h000;
  localparam logic [11:0] PCT_MAX = 12'h3e8;
  localparam logic [11:0] DEV_RST = 12'h01e;
  localparam logic [11:0] HIGH_RST = 12'h3e8;
  localparam logic [11:0] LOW_RST = 12'h000;
  localparam logic [2:0] RATE_4800 = 3'h4;
  localparam logic [2:0] RATE_19200 = 3'h6;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;
  localparam logic [5:0] NODE_MIN = 6'h01;
  localparam logic [5:0] NODE_MAX = 6'h20;
  localparam logic [13:0] WDOG_MAX = 14'h270f;
  localparam logic [9:0] WAIT_MAX = 10'h3e8;
  localparam logic [7:0] FUNC_DEVIATION = 8'h04;
  localparam logic [7:0] LINK_TRIP_VALUE = 8'h3c;

  // ------------------------------------------------------------------
  // Link error reactions
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    REACT_TRIP = 3'b000,
    REACT_DECEL_TRIP = 3'b001,
    REACT_IGNORE = 3'b010,
    REACT_COAST = 3'b011,
    REACT_DECEL = 3'b100
  } reaction_t;

  // ------------------------------------------------------------------
  // Timing: watchdog step of 10 ms, reply wait step of 1 ms
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int WDOG_STEP_MS = 10;
  localparam int WAIT_STEP_MS = 1;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int WDOG_STEP_CYC = WDOG_STEP_MS * CYC_PER_MS;
  localparam int WAIT_STEP_CYC = WAIT_STEP_MS * CYC_PER_MS;

  // Live drive quantities sampled every cycle.
  typedef struct packed {
    logic [11:0] motorCurrent;
    logic [11:0] outFreq;
    logic [11:0] setpointValue;
    logic [11:0] processValue;
  } drive_meas_t;

  // Reaction requests towards the drive sequencer.
  typedef struct packed {
    logic trip;
    logic decelTrip;
    logic coast;
    logic decel;
  } react_req_t;

endpackage : drive_status_pkg

// *** logic/drive_status_outputs.sv ***
// Status output comparators, link settings, watchdog and reply delay.
// Assumes all inputs are synchronous to core_clk and an APB master drives
// the register port with zero or more idle cycles between transfers.
//
// The implementer's own choices: the APB slave port and the register offsets.
module drive_status_outputs
  import drive_status_pkg::*;
#(
  parameter int WDOG_CYC = WDOG_STEP_CYC,
  parameter int WAIT_CYC = WAIT_STEP_CYC
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire drive_meas_t meas,
  input wire logic rampUp,
  input wire logic rampDown,
  input wire logic driveRun,
  input wire logic linkActivity,
  input wire logic linkRxDone,
  input wire logic linkErrorIn,
  output logic overloadWarning,
  output logic arrivalAtOrAbove,
  output logic pidDeviationFlag,
  output logic pidSecondStage,
  output logic linkLossFlag,
  output logic replyGo,
  output react_req_t reactReq,
  output logic [7:0] linkTripCode,
  output logic [2:0] linkRateSelect,
  output logic [5:0] nodeAddress,
  output logic [1:0] paritySelect,
  output logic [1:0] stopBitsSelect,
  output logic irq
);

  // ------------------------------------------------------------------
  // Setting registers
  // ------------------------------------------------------------------
  logic [11:0] overloadThreshold;
  logic [11:0] accelArrivalThreshold;
  logic [11:0] decelArrivalThreshold;
  logic [11:0] pidDeviationLimit;
  logic [11:0] secondStageHighLimit;
  logic [11:0] secondStageLowLimit;
  reaction_t linkErrorReaction;
  logic [13:0] linkWatchdogPeriod;
  logic [9:0] replyWaitTime;
  logic [7:0] outFuncSelect;
  logic [3:0] irqStatus;
  logic [3:0] irqMask;
  logic [11:0] pidError;

  // Bus decode.
  logic setup;
  logic wrOk;
  logic badAddr;
  logic badData;
  logic [31:0] next_prdata;
  assign setup = psel & ~penable;
  assign wrOk = psel & penable & pready & pwrite & ~pslverr;

  // Range check on setup; an out-of-range value is refused, not clipped,
  // so software learns about the mistake through pslverr.
  always_comb
  begin
    badData = 1'b0;
    unique case (paddr)
      OFF_OVL: badData = pwdata[11:0] > OVL_MAX;
      OFF_ACC, OFF_DEC: badData = pwdata[11:0] > FREQ_MAX;
      OFF_DEV, OFF_HIGH, OFF_LOW: badData = pwdata[11:0] > PCT_MAX;
      OFF_LINK: badData = pwdata[2:0] < RATE_4800 || pwdata[2:0] > RATE_19200
        || pwdata[9:8] > PAR_ODD || pwdata[17:16] < STOP_ONE
        || pwdata[17:16] > STOP_TWO;
      OFF_NODE: badData = pwdata[5:0] < NODE_MIN || pwdata[5:0] > NODE_MAX;
      OFF_REACT: badData = pwdata[2:0] > REACT_DECEL;
      OFF_WDOG: badData = pwdata[13:0] > WDOG_MAX;
      OFF_WAIT: badData = pwdata[9:0] > WAIT_MAX;
      default: badData = 1'b0;
    endcase
  end

  // Read mux; unmapped offsets read zero and answer with an error.
  always_comb
  begin
    next_prdata = 32'h0;
    badAddr = 1'b0;
    case (paddr)
      OFF_OVL: next_prdata[11:0] = overloadThreshold;
      OFF_ACC: next_prdata[11:0] = accelArrivalThreshold;
      OFF_DEC: next_prdata[11:0] = decelArrivalThreshold;
      OFF_DEV: next_prdata[11:0] = pidDeviationLimit;
      OFF_HIGH: next_prdata[11:0] = secondStageHighLimit;
      OFF_LOW: next_prdata[11:0] = secondStageLowLimit;
      OFF_LINK:
      begin
        next_prdata[LINK_RATE_LSB +: 3] = linkRateSelect;
        next_prdata[LINK_PAR_LSB +: 2] = paritySelect;
        next_prdata[LINK_STOP_LSB +: 2] = stopBitsSelect;
      end
      OFF_NODE: next_prdata[5:0] = nodeAddress;
      OFF_REACT: next_prdata[2:0] = linkErrorReaction;
      OFF_WDOG: next_prdata[13:0] = linkWatchdogPeriod;
      OFF_WAIT: next_prdata[9:0] = replyWaitTime;
      OFF_FUNC: next_prdata[7:0] = outFuncSelect;
      OFF_STAT: next_prdata[4:0] = {linkLossFlag, pidSecondStage,
        pidDeviationFlag, arrivalAtOrAbove, overloadWarning};
      OFF_IRQ: next_prdata[3:0] = irqStatus;
      OFF_MASK: next_prdata[3:0] = irqMask;
      OFF_PERR: next_prdata[11:0] = pidError;
      default: badAddr = 1'b1;
    endcase
  end

  // ------------------------------------------------------------------
  // APB answer: ready in the first cycle of the access phase, from flip-flops
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & (badAddr | (pwrite & badData));
      prdata <= (setup & ~pwrite) ? next_prdata : 32'h0;
    end
  end

  // Setting registers; defaults mirror the factory values.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      overloadThreshold <= OVL_RST;
      accelArrivalThreshold <= FREQ_RST;
      decelArrivalThreshold <= FREQ_RST;
      pidDeviationLimit <= DEV_RST;
      secondStageHighLimit <= HIGH_RST;
      secondStageLowLimit <= LOW_RST;
      linkRateSelect <= RATE_4800;
      paritySelect <= PAR_NONE;
      stopBitsSelect <= STOP_ONE;
      nodeAddress <= NODE_MIN;
      linkErrorReaction <= REACT_IGNORE;
      linkWatchdogPeriod <= 14'h0;
      replyWaitTime <= 10'h0;
      outFuncSelect <= FUNC_DEVIATION;
      irqMask <= 4'h0;
      linkTripCode <= LINK_TRIP_VALUE;
    end
    else if (wrOk)
    begin
      case (paddr)
        OFF_OVL: overloadThreshold <= pwdata[11:0];
        OFF_ACC: accelArrivalThreshold <= pwdata[11:0];
        OFF_DEC: decelArrivalThreshold <= pwdata[11:0];
        OFF_DEV: pidDeviationLimit <= pwdata[11:0];
        OFF_HIGH: secondStageHighLimit <= pwdata[11:0];
        OFF_LOW: secondStageLowLimit <= pwdata[11:0];
        OFF_LINK:
        begin
          linkRateSelect <= pwdata[LINK_RATE_LSB +: 3];
          paritySelect <= pwdata[LINK_PAR_LSB +: 2];
          stopBitsSelect <= pwdata[LINK_STOP_LSB +: 2];
        end
        OFF_NODE: nodeAddress <= pwdata[5:0];
        OFF_REACT: linkErrorReaction <= reaction_t'(pwdata[2:0]);
        OFF_WDOG: linkWatchdogPeriod <= pwdata[13:0];
        OFF_WAIT: replyWaitTime <= pwdata[9:0];
        OFF_FUNC: outFuncSelect <= pwdata[7:0];
        OFF_MASK: irqMask <= pwdata[3:0];
        default: linkTripCode <= linkTripCode;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------------
  // Overload warning is only a flag; nothing here feeds the trip path.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      overloadWarning <= 1'b0;
    else
      overloadWarning <= meas.motorCurrent > overloadThreshold;
  end

  // Arrival edges: rising edge on the accel ramp, falling on decel ramp.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      arrivalAtOrAbove <= 1'b0;
    else if (meas.outFreq == 12'h0)
      arrivalAtOrAbove <= 1'b0;
    else if (rampUp)
      arrivalAtOrAbove <= meas.outFreq >= accelArrivalThreshold;
    else if (rampDown)
      arrivalAtOrAbove <= meas.outFreq >= decelArrivalThreshold;
  end

  // PID error magnitude and the deviation flag one cycle behind it.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pidError <= 12'h0;
      pidDeviationFlag <= 1'b0;
    end
    else
    begin
      pidError <= (meas.setpointValue >= meas.processValue)
        ? meas.setpointValue - meas.processValue
        : meas.processValue - meas.setpointValue;
      pidDeviationFlag <= outFuncSelect == FUNC_DEVIATION
        && pidError > pidDeviationLimit;
    end
  end

  // Second stage hysteresis; leaving run mode wins over every limit.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pidSecondStage <= 1'b0;
    else if (!driveRun)
      pidSecondStage <= 1'b0;
    else if (meas.processValue > secondStageHighLimit)
      pidSecondStage <= 1'b0;
    else if (meas.processValue < secondStageLowLimit)
      pidSecondStage <= 1'b1;
  end

  // ------------------------------------------------------------------
  // Link watchdog, counted in 10 ms steps
  // ------------------------------------------------------------------
  logic [$clog2(WDOG_CYC)-1:0] wdDiv;
  logic [13:0] wdCount;
  logic wdExpired;
  logic errEvent;
  assign wdExpired = linkWatchdogPeriod != 14'h0
    && wdCount >= linkWatchdogPeriod;

  // Activity restarts both the divider and the step count.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wdDiv <= '0;
      wdCount <= 14'h0;
      linkLossFlag <= 1'b0;
    end
    else if (linkActivity)
    begin
      wdDiv <= '0;
      wdCount <= 14'h0;
      linkLossFlag <= 1'b0;
    end
    else
    begin
      if (wdDiv == ($clog2(WDOG_CYC))'(WDOG_CYC - 1))
      begin
        wdDiv <= '0;
        if (!wdExpired)
          wdCount <= wdCount + 14'h1;
      end
      else
        wdDiv <= wdDiv + 1'b1;
      linkLossFlag <= wdExpired;
    end
  end

  // An error event is a fresh expiry or an error from the link receiver.
  assign errEvent = linkErrorIn | (wdExpired & ~linkLossFlag & ~linkActivity);

  // Reaction requests are one-cycle pulses to the drive sequencer.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reactReq <= '0;
    else
    begin
      reactReq <= '0;
      if (errEvent)
      begin
        case (linkErrorReaction)
          REACT_TRIP: reactReq.trip <= 1'b1;
          REACT_DECEL_TRIP: reactReq.decelTrip <= 1'b1;
          REACT_COAST: reactReq.coast <= 1'b1;
          REACT_DECEL: reactReq.decel <= 1'b1;
          default: reactReq <= '0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Reply hold-off in 1 ms steps
  // ------------------------------------------------------------------
  logic [$clog2(WAIT_CYC)-1:0] waitDiv;
  logic [9:0] waitLeft;
  logic waitBusy;

  // A new message restarts the delay; the reply may then go out.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitDiv <= '0;
      waitLeft <= 10'h0;
      waitBusy <= 1'b0;
      replyGo <= 1'b0;
    end
    else
    begin
      replyGo <= 1'b0;
      if (linkRxDone)
      begin
        waitDiv <= '0;
        waitLeft <= replyWaitTime;
        waitBusy <= 1'b1;
      end
      else if (waitBusy)
      begin
        if (waitLeft == 10'h0)
        begin
          waitBusy <= 1'b0;
          replyGo <= 1'b1;
        end
        else if (waitDiv == ($clog2(WAIT_CYC))'(WAIT_CYC - 1))
        begin
          waitDiv <= '0;
          waitLeft <= waitLeft - 10'h1;
        end
        else
          waitDiv <= waitDiv + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupts: set wins over a write-one-to-clear in the same cycle
  // ------------------------------------------------------------------
  logic [3:0] irqSet;
  logic ovlPrev;
  logic devPrev;
  assign irqSet = {pidDeviationFlag & ~devPrev, linkErrorIn,
    wdExpired & ~linkLossFlag, overloadWarning & ~ovlPrev};

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqStatus <= 4'h0;
      ovlPrev <= 1'b0;
      devPrev <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      ovlPrev <= overloadWarning;
      devPrev <= pidDeviationFlag;
      irqStatus <= (irqStatus & ~((wrOk && paddr == OFF_IRQ) ? pwdata[3:0] : 4'h0))
        | irqSet;
      irq <= |(irqStatus & irqMask);
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  AST_OVERLOAD: assert property (
    overloadWarning == $past(meas.motorCurrent > overloadThreshold))
    else $error("Overload warning does not follow current.");
  AST_NO_TRIP: assert property (
    (reactReq.trip || reactReq.decelTrip) |-> $past(errEvent))
    else $error("Trip requested without a link error.");
  AST_ACCEL: assert property (
    (rampUp && meas.outFreq != 12'h0 && meas.outFreq >= accelArrivalThreshold)
    |=> arrivalAtOrAbove)
    else $error("Arrival missing on accel ramp.");
  AST_DECEL: assert property (
    (!rampUp && rampDown && meas.outFreq < decelArrivalThreshold) |=> !arrivalAtOrAbove)
    else $error("Arrival held on decel ramp.");
  AST_ERROR: assert property (
    ##1 pidError == (($past(meas.setpointValue) >= $past(meas.processValue))
      ? $past(meas.setpointValue) - $past(meas.processValue)
      : $past(meas.processValue) - $past(meas.setpointValue)))
    else $error("PID error magnitude wrong.");
  AST_DEVIATION: assert property (
    pidDeviationFlag |-> $past(outFuncSelect) == FUNC_DEVIATION)
    else $error("Deviation flag without its option.");
  AST_DEV_LIMIT: assert property (pidDeviationLimit <= PCT_MAX)
    else $error("Deviation limit out of range.");
  AST_HIGH: assert property (
    (meas.processValue > secondStageHighLimit) |=> !pidSecondStage)
    else $error("Second stage held above high limit.");
  AST_LOW: assert property (
    (driveRun && meas.processValue < secondStageLowLimit
      && meas.processValue <= secondStageHighLimit) |=> pidSecondStage)
    else $error("Second stage not set below low limit.");
  AST_LINK_CFG: assert property (
    linkRateSelect inside {[RATE_4800:RATE_19200]} && paritySelect <= PAR_ODD)
    else $error("Link settings out of range.");
  AST_NODE: assert property (
    nodeAddress >= NODE_MIN && nodeAddress <= NODE_MAX)
    else $error("Node address out of range.");
  AST_REPLY: assert property (
    (linkRxDone && replyWaitTime == 10'h0) |-> ##2 replyGo)
    else $error("Zero wait reply late.");
  AST_RELEASE: assert property (linkActivity |=> !linkLossFlag)
    else $error("Link loss held after traffic.");
  AST_STOP: assert property ($fell(driveRun) |=> !pidSecondStage)
    else $error("Second stage kept after stop.");
  AST_WDOG_OFF: assert property (
    (linkWatchdogPeriod == 14'h0) [*2] |-> !linkLossFlag)
    else $error("Link loss with watchdog disabled.");

  COV_LOSS: cover property ($rose(linkLossFlag));
  COV_STAGE: cover property ($rose(pidSecondStage) ##[1:50] $fell(pidSecondStage));
  COV_REPLY: cover property (linkRxDone ##[1:20] replyGo);
  COV_TRIP: cover property (reactReq.trip);

endmodule : drive_status_outputs

// *** testbench/link_master_model.sv ***
// Serial network master model that polls the drive over the link.
// Assumes the bench asks for one message or one bad frame at a time.
module link_master_model
  import drive_status_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sendMsg,
  input wire logic sendBad,
  input wire logic [5:0] targetNode,
  input wire logic [5:0] nodeAddress,
  input wire logic [2:0] linkRateSelect,
  input wire logic [1:0] paritySelect,
  input wire logic [1:0] stopBitsSelect,
  output logic linkActivity,
  output logic linkRxDone,
  output logic linkErrorIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Framing
  // ----------
  logic cfgOk;
  logic good;
  // The master frames only at a rate, parity and stop setting it also supports.
  assign cfgOk = linkRateSelect >= RATE_4800 && linkRateSelect <= RATE_19200
    && paritySelect <= PAR_ODD
    && stopBitsSelect >= STOP_ONE && stopBitsSelect <= STOP_TWO;
  // A frame for another node is not traffic for this drive.
  assign good = sendMsg & cfgOk & (targetNode == nodeAddress);
  // Events are one-cycle pulses, one edge after each request.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      linkActivity <= 1'h0;
      linkRxDone <= 1'h0;
      linkErrorIn <= 1'h0;
    end
    else
    begin
      linkActivity <= good;
      linkRxDone <= good;
      linkErrorIn <= sendBad;
    end
  end
endmodule : link_master_model

// *** testbench/testbench.sv ***
// Self-checking bench for the drive status block, driven over APB.
// Assumes the link master model makes all link event pulses.
module testbench
  import drive_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Signals
  // ----------
  logic core_clk = 1'h0;
  logic arst_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rampUp = 1'h0, rampDown = 1'h0, driveRun = 1'h0;
  drive_meas_t meas = '0;
  logic sendMsg = 1'h0, sendBad = 1'h0, clrSeen = 1'h0;
  logic [5:0] targetNode = 6'h01, nodeAddress;
  logic linkActivity, linkRxDone, linkErrorIn, replyGo, irq;
  logic overloadWarning, arrivalAtOrAbove, pidDeviationFlag, pidSecondStage, linkLossFlag;
  react_req_t reactReq;
  logic [3:0] seenReact = 4'h0;
  logic [7:0] linkTripCode;
  logic [2:0] linkRateSelect;
  logic [1:0] paritySelect, stopBitsSelect;
  int nMismatch = 0, checksDone = 0, n;
  logic [7:0] ra[11] = '{OFF_OVL, OFF_ACC, OFF_DEC, OFF_DEV, OFF_HIGH, OFF_LOW, OFF_LINK,
    OFF_NODE, OFF_REACT, OFF_WDOG, OFF_WAIT};
  logic [31:0] rv[11] = '{32'(OVL_RST), 32'(FREQ_RST), 32'(FREQ_RST), 32'(DEV_RST),
    32'(HIGH_RST), 32'(LOW_RST),
    32'h10004, 32'h1, 32'h2, 32'h0, 32'h0};
  logic [11:0] ps[3] = '{12'h096, 12'h064, 12'h096};
  logic [11:0] pp[3] = '{12'h078, 12'h096, 12'h064};
  logic [11:0] pe[3] = '{12'h01e, 12'h032, 12'h032};
  logic [11:0] sv[5] = '{12'h032, 12'h1f4, 12'h3b6, 12'h032, 12'h032};
  // Short counts keep the watchdog and reply waits to a few cycles.
  drive_status_outputs #(.WDOG_CYC(8), .WAIT_CYC(4)) dut (.core_clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .meas, .rampUp, .rampDown, .driveRun,
    .linkActivity, .linkRxDone, .linkErrorIn, .overloadWarning, .arrivalAtOrAbove,
    .pidDeviationFlag, .pidSecondStage, .linkLossFlag, .replyGo, .reactReq, .linkTripCode,
    .linkRateSelect, .nodeAddress, .paritySelect, .stopBitsSelect, .irq);
  link_master_model master (.core_clk, .arst_n, .sendMsg, .sendBad, .targetNode, .nodeAddress,
    .linkRateSelect, .paritySelect, .stopBitsSelect, .linkActivity, .linkRxDone, .linkErrorIn);
  always #5 core_clk = ~core_clk;
  // Reaction pulses last one cycle, so they are gathered here between requests.
  always @(posedge core_clk)
  begin
    seenReact <= clrSeen ? 4'h0 : seenReact | reactReq;
  end
  // ----------
  // Tasks
  // ----------
  task automatic giveVerdict();
    $display("checks %0d, mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : giveVerdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1)
    begin
      nMismatch++;
      giveVerdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask : apb
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle
  // A request clears the gathered reactions, so each check sees only its own.
  task automatic send(input logic bad);
    @(posedge core_clk);
    sendBad <= bad;
    sendMsg <= !bad;
    clrSeen <= 1'h1;
    @(posedge core_clk);
    sendBad <= 1'h0;
    sendMsg <= 1'h0;
    clrSeen <= 1'h0;
  endtask : send
  task automatic waitHi(ref logic s);
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (s !== 1'h1 && n < 100);
    if (s !== 1'h1)
    begin
      nMismatch++;
      giveVerdict();
    end
  endtask : waitHi
  // ----------
  // Scenarios
  // ----------
  initial
  begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'h1;
    for (int i = 0; i < 11; i++)
    begin
      apb(1'h0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    chk(linkTripCode, LINK_TRIP_VALUE);
    apb(1'h1, OFF_OVL, 32'h7d1);
    chk(err, 1'h1);
    apb(1'h0, OFF_OVL, 32'h0);
    chk(rd, 32'(OVL_RST));
    apb(1'h1, OFF_NODE, 32'h21);
    chk(err, 1'h1);
    apb(1'h0, 8'h40, 32'h0);
    chk(err, 1'h1);
    for (int r = 4; r < 7; r++)
    begin
      apb(1'h1, OFF_LINK, 32'h20000 | ((r - 4) << 8) | r);
      chk({linkRateSelect, paritySelect, stopBitsSelect}, {r[2:0], 2'(r - 4), 2'h2});
    end
    apb(1'h1, OFF_NODE, 32'h20);
    chk(nodeAddress, 6'h20);
    targetNode <= 6'h20;
    for (int w = 0; w < 3; w += 2)
    begin
      apb(1'h1, OFF_WAIT, w);
      send(1'h0);
      waitHi(replyGo);
      chk(n, 2 + w * 4);
    end
    apb(1'h1, OFF_OVL, 32'h1f4);
    @(posedge core_clk);
    meas.motorCurrent <= 12'h1f5;
    settle();
    chk({overloadWarning, seenReact}, 5'h10);
    @(posedge core_clk);
    meas.motorCurrent <= 12'h1f4;
    settle();
    chk(overloadWarning, 1'h0);
    // The first case sits exactly on the default limit of 3.0 percent.
    for (int i = 0; i < 3; i++)
    begin
      @(posedge core_clk);
      meas.setpointValue <= ps[i];
      meas.processValue <= pp[i];
      settle();
      apb(1'h0, OFF_PERR, 32'h0);
      chk({rd[11:0], pidDeviationFlag}, {pe[i], i > 0});
    end
    apb(1'h1, OFF_FUNC, 32'h0);
    settle();
    chk(pidDeviationFlag, 1'h0);
    apb(1'h1, OFF_HIGH, 32'h384);
    apb(1'h1, OFF_LOW, 32'h64);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge core_clk);
      driveRun <= i < 4;
      meas.processValue <= sv[i];
      settle();
      chk(pidSecondStage, 5'h0b >> i & 1);
    end
    apb(1'h1, OFF_ACC, 32'h64);
    apb(1'h1, OFF_DEC, 32'h12c);
    @(posedge core_clk);
    rampUp <= 1'h1;
    meas.outFreq <= 12'h0c8;
    settle();
    chk(arrivalAtOrAbove, 1'h1);
    @(posedge core_clk);
    rampUp <= 1'h0;
    rampDown <= 1'h1;
    settle();
    chk(arrivalAtOrAbove, 1'h0);
    // Link error bit is masked out here, so irq must stay low.
    for (int r = 0; r < 5; r++)
    begin
      apb(1'h1, OFF_REACT, r);
      send(1'h1);
      settle();
      chk({irq, seenReact}, (r == 2) ? 5'h0 : 5'h8 >> (r - (r > 2)));
    end
    apb(1'h1, OFF_REACT, 32'h3);
    apb(1'h1, OFF_MASK, 32'h2);
    // Traffic first, so the period runs from a known start.
    send(1'h0);
    apb(1'h1, OFF_WDOG, 32'h1);
    settle();
    chk(linkLossFlag, 1'h0);
    waitHi(linkLossFlag);
    chk(n, 4);
    settle();
    chk({irq, seenReact}, 5'h12);
    send(1'h0);
    apb(1'h1, OFF_WDOG, 32'h0);
    apb(1'h1, OFF_IRQ, 32'h2);
    settle();
    chk({linkLossFlag, irq}, 2'h0);
    repeat (40) @(posedge core_clk);
    chk({linkLossFlag, seenReact}, 5'h0);
    giveVerdict();
  end
endmodule : testbench
